/* dpt_field_model.sv */
// Sensor and load model: drives the timer inputs, latches the loads
`timescale 1ns/1ns
`default_nettype none
module dpt_field_model (
   // Clock and input polarity
   input wire logic pclk,
   input wire logic pnp,
   // Commanded contacts: gate, reset b, reset a, start
   input wire logic [3:0] act,
   // Timer inputs
   output logic start_in,
   output logic reset_a_in,
   output logic reset_b_in,
   output logic gate_in,
   // Loads
   input wire logic first_output,
   input wire logic second_output,
   output logic [1:0] load_q
);
   // Sourcing contacts drive high when closed, sinking ones pull low
   assign {gate_in, reset_b_in, reset_a_in, start_in} = pnp ? act : ~act;

   // Loads pick up the output levels one cycle later
   always_ff @(posedge pclk) begin
      load_q <= {second_output, first_output};
   end
endmodule : dpt_field_model
`default_nettype wire

/* dpt_filter.sv */
// Module: minimum signal width filter for the timer inputs
`timescale 1ns/1ns
`default_nettype none
module dpt_filter import dpt_pkg::*; #(
   parameter int unsigned NARROW = W1_CYC,
   parameter int unsigned WIDE = W20_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Lanes
   dpt_flt_if.filt f
);
   logic [CW-1:0] cnt_q [NIN];
   logic [NIN-1:0] clean_q;
   logic [CW-1:0] lim;

   // Width limit from the selected minimum width
   assign lim = f.wide ? CW'(WIDE - 1) : CW'(NARROW - 1);

   // A lane follows its input once it has held for the full width
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clean_q <= '0;
         for (int i = 0; i < NIN; i++) begin
            cnt_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NIN; i++) begin
            if (f.raw[i] == clean_q[i]) begin
               cnt_q[i] <= '0;
            end else if (cnt_q[i] == lim) begin
               clean_q[i] <= f.raw[i]; // [R8]
               cnt_q[i] <= '0;
            end else begin
               cnt_q[i] <= cnt_q[i] + 1'b1;
            end
         end
      end
   end

   assign f.clean = clean_q;
endmodule : dpt_filter
`default_nettype wire

/* dpt_flt_if.sv */
// Interface: raw and filtered input lanes with width select
`timescale 1ns/1ns
`default_nettype none
interface dpt_flt_if;
   import dpt_pkg::*;
   logic [NIN-1:0] raw;
   logic wide;
   logic [NIN-1:0] clean;
   modport filt (input raw, input wide, output clean);
   modport user (output raw, output wide, input clean);
endinterface : dpt_flt_if
`default_nettype wire

/* dpt_pkg.sv */
// Package: constants and types for the dual output preset timer
// Operation
// [R1] Reset input clears present value to zero
// [R2] Reset input halts timing, control output off
// [R3] Reset indicator lit while reset active
// [R4] Forecast mode: second output at set value
// [R5] Forecast mode: first output at forecast value
// [R6] Absolute mode: second output at value two
// [R7] Absolute mode: first output at value one
// [R8] Outputs off after reset within width delay
// [R9] Both reset terminals act identically
// [R10] Indicators follow their output states
// [R11] Decimal point flashes while timing, min/h ranges
// [R12] Reset key clears value and outputs
// [R13] Key protect locks keys per pins 6-8
// [R14] Key protect switch acts live
// [R15] Key protect indicator follows switch
// [R16] Key protect refuses function setting entry
// [R17] Pins 1-2 select time range
// [R18] Pins 3-5 select mode, width, polarity
// [R19] Switches sampled only at power-up
// [R20] Start begins timing, gate suspends counting
package dpt_pkg;
   // Timing figures, each in its own unit
   localparam int unsigned CLK_NS = 20;
   localparam int unsigned TICK_NS = 10_000_000;
   localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
   localparam int unsigned W1_US = 1000;
   localparam int unsigned W20_US = 20000;
   localparam int unsigned W1_CYC = W1_US * 1000 / CLK_NS;
   localparam int unsigned W20_CYC = W20_US * 1000 / CLK_NS;
   // Widths
   localparam int CW = 20;
   localparam int PW = 24;
   localparam int DW = 16;
   localparam int NIN = 3;
   // Present value limit and set value defaults
   localparam logic [PW-1:0] PV_MAX = 24'hf423f;
   localparam logic [PW-1:0] SV1_RST = 24'h0003e8;
   localparam logic [PW-1:0] SV2_RST = 24'h000064;
   // Base ticks per count unit, and per half blink period
   localparam logic [DW-1:0] DIV_S001 = 16'h0001;
   localparam logic [DW-1:0] DIV_HMS = 16'h0064;
   localparam logic [DW-1:0] DIV_M01 = 16'h0258;
   localparam logic [DW-1:0] DIV_H01 = 16'h8ca0;
   localparam logic [DW-1:0] BLINK_DIV = 16'h0032;
   // Register byte addresses
   localparam logic [11:0] A_KEY = 12'h000;
   localparam logic [11:0] A_SV1 = 12'h004;
   localparam logic [11:0] A_SV2 = 12'h008;
   localparam logic [11:0] A_PV = 12'h00c;
   localparam logic [11:0] A_STAT = 12'h010;
   // Switch pin positions, pin n at bit n-1
   localparam int DIP_RNG_LO = 0;
   localparam int DIP_RNG_HI = 1;
   localparam int DIP_OMODE = 2;
   localparam int DIP_WIDTH = 3;
   localparam int DIP_PNP = 4;
   localparam int DIP_LK_RST = 5;
   localparam int DIP_LK_UP = 6;
   localparam int DIP_LK_MODE = 7;
   // Filtered input lanes
   localparam int IN_START = 0;
   localparam int IN_RST = 1;
   localparam int IN_GATE = 2;

   // Time range, coded as {pin 2, pin 1}
   typedef enum logic [1:0] {
      RNG_H01 = 2'b00,
      RNG_S001 = 2'b01,
      RNG_HMS = 2'b10,
      RNG_M01 = 2'b11
   } dpt_rng_t;

   // Timing state, Gray along idle, run, hold
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_HOLD = 2'b11
   } dpt_state_t;

   // Key register write layout
   typedef struct packed {
      logic [27:0] pad;
      logic fn_exit;
      logic fn_enter;
      logic mode;
      logic rst;
   } dpt_key_t;

   // Status register read layout
   typedef struct packed {
      logic [17:0] pad;
      logic dp;
      logic pnp;
      logic wide;
      logic [1:0] rng;
      logic abs_md;
      logic sv_sel;
      logic fn;
      logic kp;
      logic rst;
      logic hold;
      logic run;
      logic o2;
      logic o1;
   } dpt_stat_t;

   // Present value has reached a compare value
   function automatic logic f_reached(input logic [PW-1:0] pv,
                                      input logic [PW-1:0] sv);
      return pv >= sv;
   endfunction : f_reached
endpackage : dpt_pkg

/* dpt_top.sv */
// Module: dual output preset timer core with APB register access
`timescale 1ns/1ns
`default_nettype none
module dpt_top import dpt_pkg::*; #(
   parameter int unsigned TICK_C = TICK_CYC,
   parameter int unsigned W1C = W1_CYC,
   parameter int unsigned W20C = W20_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer inputs
   input wire logic start_in,
   input wire logic reset_a_in,
   input wire logic reset_b_in,
   input wire logic gate_in,
   // Switches
   input wire logic key_protect_sw,
   input wire logic [7:0] dip_sw,
   // Outputs and indicators
   output logic first_output,
   output logic second_output,
   output logic first_output_ind,
   output logic second_output_ind,
   output logic reset_ind,
   output logic keyprot_ind,
   output logic dp_flash
);
   dpt_flt_if flt ();

   logic [7:0] cfg_q;
   logic cfg_ok_q;
   dpt_rng_t rng;
   logic abs_md;
   logic pnp;
   dpt_state_t st_q;
   logic start_d_q;
   logic rst_lvl;
   logic gate_lvl;
   logic start_rise;
   logic clr;
   logic armed;
   logic kp;
   logic lk_rst;
   logic lk_up;
   logic lk_mode;
   logic wr;
   logic key_wr;
   dpt_key_t key;
   logic rkey;
   logic mkey;
   logic fn_q;
   logic sv_sel_q;
   logic [PW-1:0] sv1_q;
   logic [PW-1:0] sv2_q;
   logic [PW-1:0] pv_q;
   logic [PW-1:0] fc_val;
   logic [CW-1:0] cyc_q;
   logic base_tick;
   logic [DW-1:0] div_q;
   logic [DW-1:0] div_lim;
   logic unit_tick;
   logic [DW-1:0] bl_q;
   logic blink_q;
   logic o1_d;
   logic o2_d;
   logic rd_err;
   logic [31:0] rd_mux;
   dpt_stat_t stat;

   // Input level as seen by the timer for the selected polarity
   function automatic logic f_act(input logic sourcing,
                                  input logic pin);
      return sourcing ? pin : ~pin;
   endfunction : f_act

   // Ticks of the base count per count unit of a time range
   function automatic logic [DW-1:0] f_div(input dpt_rng_t r);
      case (r)
         RNG_S001: return DIV_S001;
         RNG_HMS: return DIV_HMS;
         RNG_M01: return DIV_M01;
         default: return DIV_H01;
      endcase
   endfunction : f_div

   // Switch settings latched once, right after power-up reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= '0;
         cfg_ok_q <= 1'b0;
      end else if (!cfg_ok_q) begin
         cfg_q <= dip_sw; // [R19]
         cfg_ok_q <= 1'b1;
      end
   end

   // Configuration decode
   assign rng = dpt_rng_t'({cfg_q[DIP_RNG_HI], cfg_q[DIP_RNG_LO]}); // [R17]
   assign abs_md = cfg_q[DIP_OMODE]; // [R18]
   assign pnp = cfg_q[DIP_PNP]; // [R18]

   // Input lanes through the width filter
   assign flt.wide = ~cfg_q[DIP_WIDTH]; // [R18]
   // One driver for the whole lane vector
   always_comb begin
      flt.raw = '0;
      flt.raw[IN_START] = f_act(pnp, start_in);
      flt.raw[IN_GATE] = f_act(pnp, gate_in);
      flt.raw[IN_RST] = f_act(pnp, reset_a_in) |
                        f_act(pnp, reset_b_in); // [R9]
   end

   dpt_filter #(
      .NARROW(W1C),
      .WIDE(W20C)
   ) u_flt (
      .pclk(pclk),
      .presetn(presetn),
      .f(flt)
   );

   assign rst_lvl = flt.clean[IN_RST];
   assign gate_lvl = flt.clean[IN_GATE];
   assign start_rise = flt.clean[IN_START] & ~start_d_q;

   // Key protection, live from the switch
   assign kp = key_protect_sw; // [R14]
   assign lk_rst = kp & cfg_q[DIP_LK_RST]; // [R13]
   assign lk_up = kp & cfg_q[DIP_LK_UP]; // [R13]
   assign lk_mode = kp & cfg_q[DIP_LK_MODE]; // [R13]

   // Register writes take effect in the access phase
   assign wr = psel & penable & pwrite;
   assign key_wr = wr & (paddr == A_KEY);
   assign key = dpt_key_t'(pwdata);
   assign rkey = key_wr & key.rst & ~lk_rst; // [R12]
   assign mkey = key_wr & key.mode & ~lk_mode; // [R13]

   // Anything that returns the timer to zero
   assign clr = rst_lvl | rkey; // [R1] [R12]
   assign armed = (st_q != ST_IDLE);

   // Start edge detector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_d_q <= 1'b0;
      end else begin
         start_d_q <= flt.clean[IN_START];
      end
   end

   // Timing state: idle until start, hold while gated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
      end else if (clr) begin
         st_q <= ST_IDLE; // [R2]
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (start_rise) begin
                  st_q <= ST_RUN; // [R20]
               end
            end
            ST_RUN: begin
               if (gate_lvl) begin
                  st_q <= ST_HOLD; // [R20]
               end
            end
            ST_HOLD: begin
               if (!gate_lvl) begin
                  st_q <= ST_RUN;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Free running base tick of 0.01 s
   assign base_tick = (cyc_q == CW'(TICK_C - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_q <= '0;
      end else if (base_tick) begin
         cyc_q <= '0;
      end else begin
         cyc_q <= cyc_q + 1'b1;
      end
   end

   // Count unit divider, runs only while counting
   assign div_lim = f_div(rng);
   assign unit_tick = base_tick & (st_q == ST_RUN) &
                      (div_q == div_lim - 1'b1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
      end else if (clr || unit_tick) begin
         div_q <= '0;
      end else if (base_tick && st_q == ST_RUN) begin
         div_q <= div_q + 1'b1;
      end
   end

   // Present value counts up, saturating at the display limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pv_q <= '0;
      end else if (clr) begin
         pv_q <= '0; // [R1] [R12]
      end else if (unit_tick && pv_q != PV_MAX) begin
         pv_q <= pv_q + 1'b1; // [R20]
      end
   end

   // Set values, written through the up keys
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sv1_q <= SV1_RST;
         sv2_q <= SV2_RST;
      end else if (wr && !lk_up) begin
         if (paddr == A_SV1) begin
            sv1_q <= pwdata[PW-1:0]; // [R13]
         end
         if (paddr == A_SV2) begin
            sv2_q <= pwdata[PW-1:0];
         end
      end
   end

   // Mode key selects the set value shown; function setting mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sv_sel_q <= 1'b0;
         fn_q <= 1'b0;
      end else begin
         if (mkey) begin
            sv_sel_q <= ~sv_sel_q;
         end
         if (key_wr && key.fn_exit) begin
            fn_q <= 1'b0;
         end else if (key_wr && key.fn_enter && !kp && !lk_mode) begin
            fn_q <= 1'b1; // [R16]
         end
      end
   end

   // Forecast value is set value less the deviation, floored at zero
   assign fc_val = (sv1_q > sv2_q) ? sv1_q - sv2_q : '0;

   // Output compares per output mode
   always_comb begin
      if (abs_md) begin
         o1_d = f_reached(pv_q, sv1_q); // [R7]
         o2_d = f_reached(pv_q, sv2_q); // [R6]
      end else begin
         o1_d = f_reached(pv_q, fc_val); // [R5]
         o2_d = f_reached(pv_q, sv1_q); // [R4]
      end
   end

   // Output flops, forced off by reset input or key
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_output <= 1'b0;
         second_output <= 1'b0;
      end else begin
         first_output <= o1_d & armed & ~clr; // [R2] [R8]
         second_output <= o2_d & armed & ~clr; // [R2] [R8]
      end
   end

   // Output indicators mirror the output flops
   assign first_output_ind = first_output; // [R10]
   assign second_output_ind = second_output; // [R10]

   // Half second blink source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bl_q <= '0;
         blink_q <= 1'b0;
      end else if (base_tick) begin
         if (bl_q == BLINK_DIV - 1'b1) begin
            bl_q <= '0;
            blink_q <= ~blink_q;
         end else begin
            bl_q <= bl_q + 1'b1;
         end
      end
   end

   // Panel indicators
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_ind <= 1'b0;
         keyprot_ind <= 1'b0;
         dp_flash <= 1'b0;
      end else begin
         reset_ind <= clr; // [R3]
         keyprot_ind <= kp; // [R15]
         dp_flash <= (st_q == ST_RUN) & blink_q &
                     (rng == RNG_M01 || rng == RNG_H01); // [R11]
      end
   end

   // Status word
   always_comb begin
      stat = '0;
      stat.o1 = first_output;
      stat.o2 = second_output;
      stat.run = (st_q == ST_RUN);
      stat.hold = (st_q == ST_HOLD);
      stat.rst = reset_ind;
      stat.kp = kp;
      stat.fn = fn_q;
      stat.sv_sel = sv_sel_q;
      stat.abs_md = abs_md;
      stat.rng = rng;
      stat.wide = flt.wide;
      stat.pnp = pnp;
      stat.dp = dp_flash;
   end

   // Read decode; unmapped addresses answer with an error
   always_comb begin
      rd_mux = '0;
      rd_err = 1'b0;
      case (paddr)
         A_KEY: rd_mux = '0;
         A_SV1: rd_mux = 32'(sv1_q);
         A_SV2: rd_mux = 32'(sv2_q);
         A_PV: rd_mux = 32'(pv_q);
         A_STAT: rd_mux = stat;
         default: rd_err = 1'b1;
      endcase
   end

   // Read data and error captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? '0 : rd_mux;
         pslverr <= rd_err;
      end
   end

   // Zero wait state slave
   assign pready = 1'b1;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_start;
      start_rise && st_q == ST_IDLE && !clr;
   endsequence

   sequence s_fc;
      !abs_md && armed && !clr;
   endsequence

   sequence s_abs;
      abs_md && armed && !clr;
   endsequence

   property p_clr_pv;
      rst_lvl |=> pv_q == '0;
   endproperty
   a_clr_pv: assert property (p_clr_pv) // [R1]
      else $error("present value not cleared by reset input");

   property p_clr_halt;
      rst_lvl |=> !second_output && st_q == ST_IDLE;
   endproperty
   a_clr_halt: assert property (p_clr_halt) // [R2]
      else $error("timing or control output active during reset");

   property p_rst_ind;
      rst_lvl |=> reset_ind;
   endproperty
   a_rst_ind: assert property (p_rst_ind) // [R3]
      else $error("reset indicator dark during reset");

   property p_fc_o2;
      s_fc ##0 f_reached(pv_q, sv1_q) |=> second_output;
   endproperty
   a_fc_o2: assert property (p_fc_o2) // [R4]
      else $error("control output missing at set value");

   property p_fc_o1;
      s_fc ##0 f_reached(pv_q, fc_val) |=> first_output;
   endproperty
   a_fc_o1: assert property (p_fc_o1) // [R5]
      else $error("forecast output missing at forecast value");

   property p_ab_o2;
      s_abs ##0 (pv_q >= sv2_q) |=> second_output;
   endproperty
   a_ab_o2: assert property (p_ab_o2) // [R6]
      else $error("second output missing at set value two");

   property p_ab_o1;
      s_abs ##0 (pv_q >= sv1_q) |=> first_output;
   endproperty
   a_ab_o1: assert property (p_ab_o1) // [R7]
      else $error("first output missing at set value one");

   property p_rst_off;
      $rose(rst_lvl) |=> !first_output && !second_output;
   endproperty
   a_rst_off: assert property (p_rst_off) // [R8]
      else $error("outputs on after filtered reset");

   property p_rkey;
      rkey |=> pv_q == '0 ##0 !first_output;
   endproperty
   a_rkey: assert property (p_rkey) // [R12]
      else $error("reset key did not clear timer");

   property p_lock;
      key_wr && key.rst && lk_rst && !rst_lvl && armed |=> armed;
   endproperty
   a_lock: assert property (p_lock) // [R13]
      else $error("locked reset key took effect");

   property p_kp_ind;
      key_protect_sw |=> keyprot_ind;
   endproperty
   a_kp_ind: assert property (p_kp_ind) // [R15]
      else $error("key protect indicator dark");

   property p_fn;
      $rose(fn_q) |-> !$past(key_protect_sw);
   endproperty
   a_fn: assert property (p_fn) // [R16]
      else $error("function mode entered under key protect");

   property p_cfg;
      cfg_ok_q |=> $stable(cfg_q);
   endproperty
   a_cfg: assert property (p_cfg) // [R19]
      else $error("configuration changed after power-up");

   property p_start;
      s_start |=> st_q == ST_RUN;
   endproperty
   a_start: assert property (p_start) // [R20]
      else $error("start edge did not begin timing");

   property p_gate;
      st_q == ST_HOLD && !clr |=> $stable(pv_q);
   endproperty
   a_gate: assert property (p_gate) // [R20]
      else $error("present value advanced while gated");
endmodule : dpt_top
`default_nettype wire

/* test_dual_output_preset_timer.sv */
// Testbench: register, timing, reset and key protect checks
`timescale 1ns/1ns
`default_nettype none
module test_dual_output_preset_timer;
   import dpt_pkg::*;
   localparam int W1 = 4;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, pa;
   logic [3:0] act = 4'h0;
   logic kp = 1'b0, pnp_md = 1'b1;
   logic [7:0] dip = 8'hf9;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, s_in, ra_in, rb_in, g_in;
   wire logic o1, o2, i1, i2, rind, kind, dp;
   wire logic [1:0] load_q;
   wire logic [2:0] mon = {dp, o2, o1};
   int num_errors = 0, tests_run = 0, cyc = 0, ta, tb, n, t;

   dpt_top #(.TICK_C(10), .W1C(W1), .W20C(16)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .start_in(s_in), .reset_a_in(ra_in),
      .reset_b_in(rb_in), .gate_in(g_in), .key_protect_sw(kp),
      .dip_sw(dip), .first_output(o1), .second_output(o2), .first_output_ind(i1),
      .second_output_ind(i2), .reset_ind(rind), .keyprot_ind(kind), .dp_flash(dp));
   dpt_field_model u_field (.pclk(pclk), .pnp(pnp_md), .act(act),
      .start_in(s_in), .reset_a_in(ra_in), .reset_b_in(rb_in),
      .gate_in(g_in), .first_output(o1), .second_output(o2),
      .load_q(load_q));

   // Clock and cycle count
   always #10 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; read data taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk

   // Power-up with a switch setting valid at the first edge after release
   task automatic pwr(input logic [7:0] d);
      presetn <= 1'b0;
      dip <= d;
      pnp_md <= d[DIP_PNP];
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask : pwr

   task automatic start_pulse();
      act[0] <= 1'b1;
      repeat (W1 + 3) @(posedge pclk);
      act[0] <= 1'b0;
      repeat (W1 + 3) @(posedge pclk);
   endtask : start_pulse

   // Wait for a watched output to rise, note the cycle
   task automatic wait_bit(input int i, input int lim, output int ts);
      int k;
      for (k = 0; k < lim && mon[i] !== 1'b1; k++) @(posedge pclk);
      ts = cyc;
      chk(mon[i], 1'b1);
   endtask : wait_bit

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (40000) @(posedge pclk);
      num_errors++;
      $display("watchdog expired at %0t", $time);
      wrap_up();
   end

   initial begin
      pwr(8'hf9);
      rdchk(A_SV1, 32'h3e8);
      rdchk(A_SV2, 32'h64);
      rdchk(A_PV, 32'h0);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[12:8], 5'h12);
      apb(1'b0, 12'h020, 32'h0);
      chk(pslverr, 1'b1);
      $display("register reset test done");
      kp <= 1'b1;
      apb(1'b1, A_SV1, 32'h5);
      rdchk(A_SV1, 32'h3e8);
      chk(kind, 1'b1);
      apb(1'b1, A_KEY, 32'h4);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[6], 1'b0);
      kp <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(kind, 1'b0);
      apb(1'b1, A_KEY, 32'h6);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[7:6], 2'b11);
      apb(1'b1, A_KEY, 32'h8);
      kp <= 1'b1;
      apb(1'b1, A_KEY, 32'h2);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[7:6], 2'b10);
      kp <= 1'b0;
      $display("key protect test done");
      apb(1'b1, A_SV1, 32'h1e);
      apb(1'b1, A_SV2, 32'ha);
      start_pulse();
      wait_bit(0, 2000, ta);
      chk(o2, 1'b0);
      wait_bit(1, 2000, tb);
      chk(tb - ta, 100);
      chk({i2, i1}, 2'b11);
      chk(dp, 1'b0);
      @(posedge pclk);
      chk(load_q, 2'b11);
      kp <= 1'b1;
      apb(1'b1, A_KEY, 32'h1);
      apb(1'b0, A_PV, 32'h0);
      chk(rd != 0, 1'b1);
      kp <= 1'b0;
      apb(1'b1, A_KEY, 32'h1);
      rdchk(A_PV, 32'h0);
      chk({o2, o1}, 2'b00);
      $display("forecast and reset key test done");
      start_pulse();
      wait_bit(0, 2000, ta);
      act[3] <= 1'b1;
      repeat (W1 + 3) @(posedge pclk);
      apb(1'b0, A_PV, 32'h0);
      pa = rd;
      repeat (40) @(posedge pclk);
      rdchk(A_PV, pa);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[3], 1'b1);
      act[3] <= 1'b0;
      $display("gate test done");
      for (t = 0; t < 2; t++) begin
         if (t == 1) begin
            start_pulse();
            wait_bit(0, 2000, ta);
         end
         act[t + 1] <= 1'b1;
         for (n = 0; n < 40 && o1 !== 1'b0; n++) @(posedge pclk);
         chk(n >= W1 && n <= W1 + 3, 1'b1);
         chk(rind, 1'b1);
         repeat (20) @(posedge pclk);
         rdchk(A_PV, 32'h0);
         chk({o2, o1}, 2'b00);
         act[t + 1] <= 1'b0;
         repeat (W1 + 3) @(posedge pclk);
      end
      $display("reset terminal test done");
      pwr(8'h1f);
      dip <= 8'h00;
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[12:8], 5'h17);
      apb(1'b1, A_SV1, 32'h2);
      apb(1'b1, A_SV2, 32'h1);
      start_pulse();
      wait_bit(2, 1000, n);
      wait_bit(1, 8000, ta);
      chk(o1, 1'b0);
      wait_bit(0, 8000, tb);
      chk(tb - ta, 6000);
      $display("absolute mode test done");
      pwr(8'h02);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[12:8], 5'h0c);
      act[0] <= 1'b1;
      repeat (W1 + 3) @(posedge pclk);
      act[0] <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[2], 1'b0);
      act[0] <= 1'b1;
      repeat (20) @(posedge pclk);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[2], 1'b1);
      act[0] <= 1'b0;
      $display("input width and polarity test done");
      wrap_up();
   end
endmodule : test_dual_output_preset_timer
`default_nettype wire
